// ---- common/rsf_pkg.sv ----
/*
  Constants, field positions and enumerations for the radio science
  frame generator. Assumes a 30 MHz reference and a 10 Msample/s input.
*/
// What this block does
// - start frames on first strobe after power-on
// - one frame every 1.024 s until off
// - frames are 5082 whole bytes
// - 1250 I/Q pairs of 16 bits each
// - first byte is sync value 183
// - fourth byte holds selection in bits 6:4
// - nonzero selection swaps input for test pattern
// - 000 feeds converter, 111 feeds zeros
// - 001 gives two 128 samples per frame
// - square waves of 256 at three rates
// - 100 and 101 give pseudo-random samples
// - square each sample into 40-bit sum
// - sum cleared per frame, ten snapshots stored
// - snapshot every 102.4 ms, first at start
// - full-frame sum leads the next frame
// - multi-byte values MSB first, interleaved
// - ten 24-bit time tags per frame
// - selection set by command, used next frame
// - tag zero after start, never frame-cleared
// - I and Q are signed two's complement
// - aux bytes at 7,10,.. repeat every 508
`default_nettype none
package rsf_pkg;
  localparam int unsigned SAMPLE_W        = 16;
  localparam int unsigned RAD_W           = 40;
  localparam int unsigned TAG_W           = 24;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned SAMPLE_RATE_HZ  = 10_000_000;
  localparam logic [1:0]  SAMPLE_DIV_LAST = 2'h2;
  localparam int unsigned FRAME_TIME_US   = 1_024_000;
  localparam int unsigned SNAPS_PER_FRAME = 10;
  localparam int unsigned SNAP_TIME_US    = FRAME_TIME_US / SNAPS_PER_FRAME;
  localparam int unsigned PAIRS_PER_SNAP  = 125;
  localparam int unsigned SNAP_SAMPLES    = SNAP_TIME_US * (SAMPLE_RATE_HZ / 1_000_000);
  localparam int unsigned PAIR_SAMPLES_DEF = SNAP_SAMPLES / PAIRS_PER_SNAP;
  localparam logic [10:0] PAIR_LAST       = 11'h04e1;
  localparam logic [6:0]  PIS_LAST        = 7'h7c;
  localparam logic [8:0]  GROUP_LAST      = 9'h1fb;
  localparam logic [8:0]  AUX_SPAN        = 9'h01e;
  localparam logic [8:0]  RAD_FIRST_OFF   = 9'h006;
  localparam logic [3:0]  LAST_GRP        = 4'ha;
  localparam logic [8:0]  LAST_OFF        = 9'h001;
  localparam logic [3:0]  AUX_K_ID        = 4'h0;
  localparam logic [3:0]  AUX_K_STATUS    = 4'h1;
  localparam logic [3:0]  AUX_K_RAD0      = 4'h2;
  localparam logic [7:0]  SYNC_BYTE       = 8'hb7;
  localparam int unsigned STATUS_SEL_LSB  = 4;
  localparam logic [15:0] IMPULSE_VAL     = 16'h0080;
  localparam logic [23:0] IMPULSE_LEN     = 24'h00_0002;
  localparam logic [15:0] SQ_POS          = 16'h0100;
  localparam logic [15:0] SQ_NEG          = 16'hff00;
  localparam logic [15:0] PRN_POS         = 16'h0001;
  localparam logic [15:0] PRN_NEG         = 16'hffff;
  localparam int unsigned SQ_LO_BIT       = 13;
  localparam int unsigned SQ_MID_BIT      = 8;
  localparam int unsigned SQ_HI_BIT       = 6;
  localparam logic [15:0] PRN_SEED        = 16'hace1;
  localparam logic [15:0] PRN_TAPS        = 16'hb400;
  typedef enum logic [2:0] {
    SEL_ADC      = 3'b000,
    SEL_IMPULSE  = 3'b001,
    SEL_SQ_LO    = 3'b010,
    SEL_SQ_MID   = 3'b011,
    SEL_PRN_UNIT = 3'b100,
    SEL_PRN_FULL = 3'b101,
    SEL_SQ_HI    = 3'b110,
    SEL_ZERO     = 3'b111
  } rsf_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b10
  } rsf_state_t;
endpackage : rsf_pkg
`default_nettype wire

// ---- rtl/rsf_frame_gen.sv ----
/*
  Frame generator: test pattern source, radiometer, time tags and the
  interleaved byte stream. Assumes power_on and src_sel come from logic
  on ref_clk; second_strobe and adc_data are pins and get synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
module rsf_frame_gen #(
  parameter int unsigned PAIR_SAMPLES = rsf_pkg::PAIR_SAMPLES_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        power_on,
  input  wire logic [2:0]  src_sel,
  input  wire logic        second_strobe,
  input  wire logic [15:0] adc_data,
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             out_first,
  output logic             out_last,
  output logic             running
);
  localparam logic [23:0] SAMP_LAST = 24'(PAIR_SAMPLES - 1);

  // one galois step of the pattern generator
  function automatic logic [15:0] prn_step(input logic [15:0] v);
    prn_step = v[0] ? ((v >> 1) ^ rsf_pkg::PRN_TAPS) : (v >> 1);
  endfunction : prn_step

  logic                  strb_s1_r, strb_s2_r, strb_s3_r;
  logic [15:0]           adc_s1_r, adc_s2_r;
  logic [1:0]            div_r, div_nxt;
  rsf_pkg::rsf_state_t   st_r, st_nxt;
  rsf_pkg::rsf_sel_t     sel_r, sel_nxt;
  rsf_pkg::rsf_sel_t     cur_sel;
  logic [23:0]           samp_r, samp_nxt;
  logic [10:0]           pair_r, pair_nxt;
  logic [6:0]            pis_r, pis_nxt;
  logic [13:0]           wave_r, wave_nxt, wave_v;
  logic [15:0]           lfsr_r, lfsr_nxt, lfsr_v;
  logic [15:0]           smp;
  logic signed [31:0]    smp_sx;
  logic [15:0]           prev_r, prev_nxt;
  logic [39:0]           sq40;
  logic [39:0]           acc_r, acc_nxt;
  logic [39:0]           rad_r, rad_nxt;
  logic [23:0]           tag_r, tag_nxt;
  logic [23:0]           tsnap_r, tsnap_nxt;
  logic [15:0]           pi_r, pi_nxt;
  logic [15:0]           pq_r, pq_nxt;
  logic                  ena, fs, snap, cap;
  logic                  strobe_rise;
  logic                  em_r, em_nxt;
  logic [3:0]            grp_r, grp_nxt;
  logic [8:0]            off_r, off_nxt;
  logic [1:0]            tri_r, tri_nxt;
  logic [3:0]            k_r, k_nxt;
  logic [1:0]            iqb_r, iqb_nxt;
  logic                  pv_r, pv_nxt;
  logic                  aux, adv;
  logic [7:0]            byte_v;
  logic                  ov_r, ov_nxt;
  logic [7:0]            od_r, od_nxt;
  logic                  of_r, of_nxt;
  logic                  ol_r, ol_nxt;

  // two-stage synchronisers for the pins; s3 only feeds edge detect
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strb_s1_r <= 1'b0;
      strb_s2_r <= 1'b0;
      strb_s3_r <= 1'b0;
      adc_s1_r  <= 16'h0000;
      adc_s2_r  <= 16'h0000;
    end else begin
      strb_s1_r <= second_strobe;
      strb_s2_r <= strb_s1_r;
      strb_s3_r <= strb_s2_r;
      adc_s1_r  <= adc_data;
      adc_s2_r  <= adc_s1_r;
    end
  end

  assign strobe_rise = strb_s2_r & ~strb_s3_r;

  // control: wait for the strobe after power-on, then run until off
  always_comb begin
    st_nxt  = st_r;
    div_nxt = (div_r == rsf_pkg::SAMPLE_DIV_LAST) ? 2'h0 : div_r + 2'h1;
    unique case (st_r)
      rsf_pkg::ST_IDLE:  if (power_on) st_nxt = rsf_pkg::ST_ARMED;
      rsf_pkg::ST_ARMED: if (!power_on) st_nxt = rsf_pkg::ST_IDLE;
                         else if (strobe_rise) st_nxt = rsf_pkg::ST_RUN;
      rsf_pkg::ST_RUN:   if (!power_on) st_nxt = rsf_pkg::ST_IDLE;
      default:           st_nxt = rsf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r  <= rsf_pkg::ST_IDLE;
      div_r <= 2'h0;
    end else begin
      st_r  <= st_nxt;
      div_r <= div_nxt;
    end
  end

  // sample timing: pairs, snapshots and frames counted in enables
  assign ena  = (st_r == rsf_pkg::ST_RUN) && (div_r == 2'h0);
  assign cap  = ena && (samp_r == 24'h00_0000);
  assign fs   = cap && (pair_r == 11'h000);
  assign snap = cap && (pis_r == 7'h00);
  assign cur_sel = fs ? rsf_pkg::rsf_sel_t'(src_sel) : sel_r;
  assign wave_v  = fs ? 14'h0000 : wave_r;
  assign lfsr_v  = fs ? rsf_pkg::PRN_SEED : lfsr_r;

  // input selection: converter or a deterministic pattern
  always_comb begin
    unique case (cur_sel)
      rsf_pkg::SEL_ADC:      smp = adc_s2_r;
      rsf_pkg::SEL_IMPULSE:  smp = (pair_r == 11'h000 && samp_r < rsf_pkg::IMPULSE_LEN)
                                   ? rsf_pkg::IMPULSE_VAL : 16'h0000;
      rsf_pkg::SEL_SQ_LO:    smp = wave_v[rsf_pkg::SQ_LO_BIT] ? rsf_pkg::SQ_NEG
                                   : rsf_pkg::SQ_POS;
      rsf_pkg::SEL_SQ_MID:   smp = wave_v[rsf_pkg::SQ_MID_BIT] ? rsf_pkg::SQ_NEG
                                   : rsf_pkg::SQ_POS;
      rsf_pkg::SEL_PRN_UNIT: smp = lfsr_v[0] ? rsf_pkg::PRN_POS : rsf_pkg::PRN_NEG;
      rsf_pkg::SEL_PRN_FULL: smp = lfsr_v;
      rsf_pkg::SEL_SQ_HI:    smp = wave_v[rsf_pkg::SQ_HI_BIT] ? rsf_pkg::SQ_NEG
                                   : rsf_pkg::SQ_POS;
      rsf_pkg::SEL_ZERO:     smp = 16'h0000;
    endcase
  end

  assign smp_sx = 32'($signed(smp)); // widen first so the square keeps all 31 bits
  assign sq40   = {8'h00, smp_sx * smp_sx};

  // counters, radiometer, tags and the captured pair
  always_comb begin
    samp_nxt  = samp_r;
    pair_nxt  = pair_r;
    pis_nxt   = pis_r;
    wave_nxt  = wave_r;
    lfsr_nxt  = lfsr_r;
    prev_nxt  = prev_r;
    acc_nxt   = acc_r;
    rad_nxt   = rad_r;
    tag_nxt   = tag_r;
    tsnap_nxt = tsnap_r;
    pi_nxt    = pi_r;
    pq_nxt    = pq_r;
    sel_nxt   = cur_sel;
    if (st_r != rsf_pkg::ST_RUN) begin
      samp_nxt = 24'h00_0000;
      pair_nxt = 11'h000;
      pis_nxt  = 7'h00;
      acc_nxt  = 40'h00_0000_0000;
      tag_nxt  = 24'h00_0000;
      sel_nxt  = sel_r;
    end else if (ena) begin
      samp_nxt = (samp_r == SAMP_LAST) ? 24'h00_0000 : samp_r + 24'h00_0001;
      if (samp_r == SAMP_LAST) begin
        pair_nxt = (pair_r == rsf_pkg::PAIR_LAST) ? 11'h000 : pair_r + 11'h001;
        pis_nxt  = (pis_r == rsf_pkg::PIS_LAST) ? 7'h00 : pis_r + 7'h01;
      end
      wave_nxt = wave_v + 14'h0001;
      lfsr_nxt = prn_step(lfsr_v);
      prev_nxt = smp;
      acc_nxt  = fs ? sq40 : acc_r + sq40;
      if (snap) begin
        rad_nxt   = acc_r;
        tsnap_nxt = tag_r;
        tag_nxt   = tag_r + 24'h00_0001;
      end
      if (cap) begin
        pi_nxt = smp;
        pq_nxt = prev_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_r  <= 24'h00_0000;
      pair_r  <= 11'h000;
      pis_r   <= 7'h00;
      wave_r  <= 14'h0000;
      lfsr_r  <= rsf_pkg::PRN_SEED;
      prev_r  <= 16'h0000;
      acc_r   <= 40'h00_0000_0000;
      rad_r   <= 40'h00_0000_0000;
      tag_r   <= 24'h00_0000;
      tsnap_r <= 24'h00_0000;
      pi_r    <= 16'h0000;
      pq_r    <= 16'h0000;
      sel_r   <= rsf_pkg::SEL_ADC;
    end else begin
      samp_r  <= samp_nxt;
      pair_r  <= pair_nxt;
      pis_r   <= pis_nxt;
      wave_r  <= wave_nxt;
      lfsr_r  <= lfsr_nxt;
      prev_r  <= prev_nxt;
      acc_r   <= acc_nxt;
      rad_r   <= rad_nxt;
      tag_r   <= tag_nxt;
      tsnap_r <= tsnap_nxt;
      pi_r    <= pi_nxt;
      pq_r    <= pq_nxt;
      sel_r   <= sel_nxt;
    end
  end

  // aux byte slots: every third byte of the first 30 of groups 0-9, from offset 6 in groups 1-9
  assign aux = (tri_r == 2'h0) && (off_r < rsf_pkg::AUX_SPAN) && (grp_r < rsf_pkg::LAST_GRP)
               && ((grp_r == 4'h0) || (off_r >= rsf_pkg::RAD_FIRST_OFF));
  assign adv = em_r && (aux || pv_r);

  // byte value for the current slot
  always_comb begin
    byte_v = 8'h00;
    if (aux) begin
      unique case (k_r)
        rsf_pkg::AUX_K_ID:     byte_v = rsf_pkg::SYNC_BYTE;
        rsf_pkg::AUX_K_STATUS: byte_v = 8'({sel_r, 4'h0});
        4'h2:    byte_v = rad_r[39:32];
        4'h3:    byte_v = rad_r[31:24];
        4'h4:    byte_v = rad_r[23:16];
        4'h5:    byte_v = rad_r[15:8];
        4'h6:    byte_v = rad_r[7:0];
        4'h7:    byte_v = tsnap_r[23:16];
        4'h8:    byte_v = tsnap_r[15:8];
        4'h9:    byte_v = tsnap_r[7:0];
        default: byte_v = 8'h00;
      endcase
    end else begin
      unique case (iqb_r)
        2'h0: byte_v = pi_r[15:8];
        2'h1: byte_v = pi_r[7:0];
        2'h2: byte_v = pq_r[15:8];
        2'h3: byte_v = pq_r[7:0];
      endcase
    end
  end

  // emitter: walks the frame positions, stalls for the next pair
  always_comb begin
    em_nxt  = em_r;
    grp_nxt = grp_r;
    off_nxt = off_r;
    tri_nxt = tri_r;
    k_nxt   = k_r;
    iqb_nxt = iqb_r;
    pv_nxt  = pv_r;
    ov_nxt  = 1'b0;
    od_nxt  = od_r;
    of_nxt  = 1'b0;
    ol_nxt  = 1'b0;
    if (adv) begin
      ov_nxt  = 1'b1;
      od_nxt  = byte_v;
      of_nxt  = (grp_r == 4'h0) && (off_r == 9'h000);
      tri_nxt = (tri_r == 2'h2) ? 2'h0 : tri_r + 2'h1;
      if (aux) begin
        k_nxt = k_r + 4'h1;
      end else begin
        iqb_nxt = iqb_r + 2'h1;
        if (iqb_r == 2'h3) pv_nxt = 1'b0;
      end
      if (off_r == rsf_pkg::GROUP_LAST) begin
        off_nxt = 9'h000;
        tri_nxt = 2'h0;
        grp_nxt = grp_r + 4'h1;
        k_nxt   = rsf_pkg::AUX_K_RAD0;
      end else begin
        off_nxt = off_r + 9'h001;
      end
      if (grp_r == rsf_pkg::LAST_GRP && off_r == rsf_pkg::LAST_OFF) begin
        em_nxt = 1'b0;
        ol_nxt = 1'b1;
      end
    end
    if (cap) pv_nxt = 1'b1; // a new pair wins over the consume
    if (fs) begin
      em_nxt  = 1'b1;
      grp_nxt = 4'h0;
      off_nxt = 9'h000;
      tri_nxt = 2'h0;
      k_nxt   = rsf_pkg::AUX_K_ID;
      iqb_nxt = 2'h0;
    end
    if (st_r != rsf_pkg::ST_RUN) begin
      em_nxt = 1'b0;
      pv_nxt = 1'b0;
      ov_nxt = 1'b0;
      of_nxt = 1'b0;
      ol_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      em_r  <= 1'b0;
      grp_r <= 4'h0;
      off_r <= 9'h000;
      tri_r <= 2'h0;
      k_r   <= 4'h0;
      iqb_r <= 2'h0;
      pv_r  <= 1'b0;
      ov_r  <= 1'b0;
      od_r  <= 8'h00;
      of_r  <= 1'b0;
      ol_r  <= 1'b0;
    end else begin
      em_r  <= em_nxt;
      grp_r <= grp_nxt;
      off_r <= off_nxt;
      tri_r <= tri_nxt;
      k_r   <= k_nxt;
      iqb_r <= iqb_nxt;
      pv_r  <= pv_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
      of_r  <= of_nxt;
      ol_r  <= ol_nxt;
    end
  end

  // outputs straight from flip-flops, running decoded from the state register
  assign out_valid = ov_r;
  assign out_data  = od_r;
  assign out_first = of_r;
  assign out_last  = ol_r;
  assign running   = (st_r == rsf_pkg::ST_RUN);
endmodule : rsf_frame_gen
`default_nettype wire

// ---- tb/rsf_frame_gen_sva.sv ----
/*
  Checker for the frame generator output stream.
  Assumes it is bound to rsf_frame_gen and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module rsf_frame_gen_sva #(
  parameter int unsigned PAIR_SAMPLES = 8
) (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        power_on,
  input wire logic [2:0]  src_sel,
  input wire logic        second_strobe,
  input wire logic [15:0] adc_data,
  input wire logic        out_valid,
  input wire logic [7:0]  out_data,
  input wire logic        out_first,
  input wire logic        out_last,
  input wire logic        running
);
  localparam int unsigned FRAME_CLKS = 3 * 1250 * PAIR_SAMPLES;
  logic [12:0] idx_r, idx_nxt;
  logic [23:0] gap_r, gap_nxt;
  logic        have_r, have_nxt;
  logic [2:0]  selq_r, selq2_r, sel_r, sel_nxt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // byte index in frame, clocks since frame start, selection of this frame
  always_comb begin
    idx_nxt  = out_valid ? (out_first ? 13'h0001 : idx_r + 13'h0001) : idx_r;
    gap_nxt  = out_first ? 24'h00_0001 : gap_r + 24'h00_0001;
    have_nxt = running && (have_r || out_first);
    sel_nxt  = out_first ? selq2_r : sel_r; // value seen at the frame-start edge
  end
  // registers the helper state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_r  <= '0;
      gap_r  <= '0;
      have_r <= 1'b0;
      selq_r <= '0;
      selq2_r <= '0;
      sel_r  <= '0;
    end else begin
      idx_r  <= idx_nxt;
      gap_r  <= gap_nxt;
      have_r <= have_nxt;
      selq_r <= src_sel;
      selq2_r <= selq_r;
      sel_r  <= sel_nxt;
    end
  end
  // six bytes follow the id byte back to back, then the stream waits for a pair
  sequence s_head;
    out_valid [*6] ##1 !out_valid;
  endsequence
  property p_frame_head;
    out_first |=> s_head;
  endproperty
  a_frame_head: assert property (p_frame_head)
    else $error("frame head bytes out of order");
  property p_sync;
    out_first |-> out_valid && out_data == 8'hb7;
  endproperty
  a_sync: assert property (p_sync)
    else $error("first byte is not the sync value");
  property p_last_len;
    out_last |-> out_valid && idx_r == 13'h13d9;
  endproperty
  a_last_len: assert property (p_last_len)
    else $error("frame length wrong");
  property p_status;
    out_valid && !out_first && idx_r == 13'h0003 |-> out_data == {1'b0, sel_r, 4'h0};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");
  property p_period;
    out_first && have_r |-> gap_r == 24'(FRAME_CLKS);
  endproperty
  a_period: assert property (p_period)
    else $error("frame period wrong");
  property p_start_armed;
    $rose(running) |-> $past(power_on);
  endproperty
  a_start_armed: assert property (p_start_armed)
    else $error("frames started without power on");
  property p_start_strobe;
    $rose(running) |-> $past(second_strobe, 3);
  endproperty
  a_start_strobe: assert property (p_start_strobe)
    else $error("frames started without strobe");
  property p_quiet_idle;
    !running && $past(!running) |-> !out_valid;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle)
    else $error("bytes emitted while not running");
endmodule : rsf_frame_gen_sva
bind rsf_frame_gen rsf_frame_gen_sva #(.PAIR_SAMPLES(PAIR_SAMPLES)) rsf_frame_gen_sva_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .power_on(power_on), .src_sel(src_sel),
  .second_strobe(second_strobe), .adc_data(adc_data), .out_valid(out_valid),
  .out_data(out_data), .out_first(out_first), .out_last(out_last), .running(running)
);
`default_nettype wire

// ---- tb/rsf_frame_sink.sv ----
/*
  Recorder model: stores each frame byte at its position, counts whole
  frames and times frame starts. Assumes the stream has no back-pressure.
*/
`timescale 1ns/1ns
`default_nettype none
module rsf_frame_sink (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_first,
  input wire logic       out_last
);
  logic [7:0] frame_mem [0:5081];
  int         wr_idx, last_len, frames_done, clk_cnt, first_at, gap;
  // accepts every byte at once, restarts position on each frame start
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_idx      <= 0;
      last_len    <= 0;
      frames_done <= 0;
      clk_cnt     <= 0;
      first_at    <= 0;
      gap         <= 0;
    end else begin
      clk_cnt <= clk_cnt + 1;
      if (out_valid) begin
        if (out_first) begin
          frame_mem[0] <= out_data;
          wr_idx       <= 1;
          gap          <= clk_cnt - first_at;
          first_at     <= clk_cnt;
        end else if (wr_idx < 5082) begin
          frame_mem[wr_idx] <= out_data;
          wr_idx            <= wr_idx + 1;
        end
        if (out_last) begin
          last_len    <= wr_idx + 1;
          frames_done <= frames_done + 1;
        end
      end
    end
  end
endmodule : rsf_frame_sink
`default_nettype wire

// ---- tb/test_radio_science_frame_generator.sv ----
/*
  Testbench for the frame generator: every input selection, then two whole
  frames. Assumes the checker is bound and PAIR_SAMPLES is shortened to 8.
*/
`timescale 1ns/1ns
`default_nettype none
module test_radio_science_frame_generator;
  localparam int unsigned PAIR_SAMPLES = 8;
  localparam int          FRAME_CLKS   = 3 * 1250 * PAIR_SAMPLES;
  logic        ref_clk, arst_n, power_on, second_strobe;
  logic        out_valid, out_first, out_last, running;
  logic [2:0]  src_sel;
  logic [15:0] adc_data;
  logic [7:0]  out_data;
  int          fails = 0;
  int          samples_checked = 0;
  // first sample of a frame for each selection
  logic [15:0] pat_first [0:7] = '{16'h1234, 16'h0080, 16'h0100, 16'h0100,
                                   16'h0001, 16'hace1, 16'h0100, 16'h0000};
  // sample 64 of a frame for each selection; pseudo-random ones unchecked
  logic [15:0] pat_mid [0:7] = '{16'h1234, 16'h0000, 16'h0100, 16'h0100,
                                 16'h0000, 16'h0000, 16'hff00, 16'h0000};
  // reference oscillator model; frame timing counts edges, not ns
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  rsf_frame_gen #(.PAIR_SAMPLES(PAIR_SAMPLES)) rsf_frame_gen_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .power_on(power_on), .src_sel(src_sel),
    .second_strobe(second_strobe), .adc_data(adc_data), .out_valid(out_valid),
    .out_data(out_data), .out_first(out_first), .out_last(out_last), .running(running)
  );
  rsf_frame_sink rsf_frame_sink_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .out_valid(out_valid),
    .out_data(out_data), .out_first(out_first), .out_last(out_last)
  );
  task automatic check_val(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : check_val
  // gathers n bytes spaced three apart, most significant first
  function automatic logic [39:0] aux_val(input int pos, input int n);
    logic [39:0] v;
    v = '0;
    for (int b = 0; b < n; b++) v = {v[31:0], rsf_frame_sink_inst.frame_mem[pos + 3 * b]};
    return v;
  endfunction : aux_val
  task automatic wait_first();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (out_first !== 1'b1 && n < 200);
    if (n >= 200) check_val(40'h1, 40'h0);
  endtask : wait_first
  task automatic wait_frame(input int cnt);
    int n;
    n = 0;
    while (rsf_frame_sink_inst.frames_done != cnt && n < FRAME_CLKS + 2000) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    check_val(40'(rsf_frame_sink_inst.frames_done), 40'(cnt));
  endtask : wait_frame
  // starts a frame on each selection, checks status and first sample, then aborts
  task automatic test_patterns();
    int quiet;
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      src_sel  <= 3'(s);
      power_on <= 1'b1;
      quiet = 0;
      repeat (20) begin
        @(posedge ref_clk);
        #1;
        if (out_valid !== 1'b0) quiet++;
      end
      check_val(40'(quiet), 40'h0);
      @(posedge ref_clk);
      second_strobe <= 1'b1;
      wait_first();
      repeat (8) @(posedge ref_clk);
      #1;
      check_val({32'h0, rsf_frame_sink_inst.frame_mem[3]}, {33'h0, 3'(s), 4'h0});
      check_val(aux_val(1, 1) << 8 | aux_val(2, 1), {24'h0, pat_first[s]});
      repeat (200) @(posedge ref_clk);
      #1;
      if (s != 4 && s != 5) begin
        check_val(aux_val(42, 1) << 8 | aux_val(43, 1), {24'h0, pat_mid[s]});
      end
      @(posedge ref_clk);
      power_on      <= 1'b0;
      second_strobe <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      check_val({39'h0, running}, 40'h0);
    end
  endtask : test_patterns
  task automatic check_frame(input logic [2:0] sel, input logic [39:0] rad0,
                             input logic [39:0] rad_rest, input int tag0);
    check_val(40'(rsf_frame_sink_inst.last_len), 40'h13da);
    check_val(aux_val(0, 1), 40'hb7);
    check_val(aux_val(3, 1), {33'h0, sel, 4'h0});
    check_val(aux_val(1, 1) << 8 | aux_val(2, 1), sel == 3'h1 ? 40'h80 : 40'h0);
    check_val(aux_val(6, 5), rad0);
    for (int g = 1; g < 10; g++) check_val(aux_val(508 * g + 6, 5), rad_rest);
    for (int g = 0; g < 10; g++) check_val(aux_val(508 * g + 21, 3), 40'(tag0 + g));
  endtask : check_frame
  // impulse frame, then all-zero frame commanded during the first
  task automatic test_frames();
    @(posedge ref_clk);
    src_sel  <= 3'h1;
    power_on <= 1'b1;
    repeat (5) @(posedge ref_clk);
    second_strobe <= 1'b1;
    wait_first();
    @(posedge ref_clk);
    second_strobe <= 1'b0;
    src_sel       <= 3'h7;
    wait_frame(1);
    check_frame(3'h1, 40'h0, 40'h8000, 0);
    wait_frame(2);
    check_frame(3'h7, 40'h8000, 40'h0, 10);
    check_val(40'(rsf_frame_sink_inst.gap), 40'(FRAME_CLKS));
    @(posedge ref_clk);
    power_on <= 1'b0;
  endtask : test_frames
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // converter input held at a fixed sample
  initial begin
    arst_n        = 1'b0;
    power_on      = 1'b0;
    src_sel       = 3'h0;
    second_strobe = 1'b0;
    adc_data      = 16'h1234;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    test_patterns();
    test_frames();
    print_verdict();
  end
  // cuts a hang short
  initial begin
    repeat (95000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
endmodule : test_radio_science_frame_generator
`default_nettype wire
